// ===== ptx_message_params.sv
// Functional notes
// - auto mode: crc follows length-th byte
// - length ignored in raw; special code ends
// - no retries: wait bit selects ack wait for software sends
// - retries with auto reply: software sends always wait
// - three-bit field picks start ordered set
// - with retry, ack sop must match
// - permit held clear on resets, rx data
// - permit sampled at trigger; else dropped
// - clearing permit never stops issued send
// - permit never gates hardware sends
// - block reset clears permit
// - ack message id compared with expected
// - header bytes pass through unchanged
// - zero retry limit disables hardware retry
// - auto reply off also disables retry
module ptx_message_params
    import ptx_pkg::*;
#(
    parameter int ACK_WAIT = ACK_WAIT_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pdBlockReset,
    input wire logic [15:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    input wire logic rawMode,
    input wire logic autoReplyEnable,
    input wire logic [2:0] retryLimit,
    input wire logic rxHardReset,
    input wire logic rxCableReset,
    input wire logic rxFifoNotEmpty,
    input wire logic goSet,
    input wire logic hwSendReq,
    input wire logic abortReq,
    input wire logic qValid,
    input wire logic [7:0] qData,
    input wire logic qSpecial,
    output logic qReady,
    output logic outValid,
    output logic [7:0] outData,
    output logic outCrc,
    input wire logic outReady,
    output logic [2:0] startOrderedSet,
    input wire logic ackValid,
    input wire logic [2:0] ackSop,
    input wire logic [2:0] ackMsgId,
    output logic txActive,
    output logic txDone,
    output logic txSuccess,
    output logic swDropped,
    output logic retryAttempt,
    output logic [2:0] retryCount
);
    if (ACK_WAIT < 1) begin : g_bad_wait
        $error("ack wait must be at least one cycle");
    end

    localparam int TW = $clog2(ACK_WAIT + 1);

    logic [LEN_W-1:0] txPacketLength;
    logic waitForAckReply;
    logic [2:0] startOrderedSetChoice;
    logic softwareSendPermit;
    logic [2:0] expectedMsgId;
    ptx_state_t state;
    logic [LEN_W-1:0] sentCount;
    logic [TW-1:0] ackTimer;
    logic hwSend;
    logic holdPermit;
    logic swStart;
    logic start;
    logic effRetry;
    logic needAck;
    logic ackGood;
    logic loadSlot;
    logic fifoValid;
    logic [8:0] fifoData;
    logic fifoPop;
    logic endOfFrame;
    logic timeout;
    logic inReset;

    // permit vetoed by receive events
    assign holdPermit = rxHardReset || rxCableReset || rxFifoNotEmpty;
    assign swStart = goSet && softwareSendPermit && !holdPermit;
    assign start = (state == ST_IDLE) && (swStart || hwSendReq);
    // retry only when limit nonzero and auto reply on
    assign effRetry = autoReplyEnable && (retryLimit != 3'h0);
    // software sends wait for ack: forced by retry, otherwise by the wait bit; hardware sends never wait
    assign needAck = !hwSend && (effRetry || waitForAckReply);
    // ack accepted only on id match and, under retry, sop match
    assign ackGood = ackValid && (ackMsgId == expectedMsgId)
        && (!effRetry || ackSop == startOrderedSetChoice);
    assign loadSlot = !outValid || outReady;
    assign fifoPop = (state == ST_SEND) && loadSlot && fifoValid;
    assign endOfFrame = outValid && outReady && outCrc;
    assign timeout = ackTimer == TW'(ACK_WAIT);
    assign startOrderedSet = startOrderedSetChoice;

    ptx_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .flush(pdBlockReset),
        .inValid(qValid),
        .inData({qSpecial, qData}),
        .inReady(qReady),
        .outValid(fifoValid),
        .outData(fifoData),
        .outReady(fifoPop)
    );

    // register writes
    always_ff @(posedge clk) begin
        if (!rst_n || pdBlockReset) begin
            txPacketLength <= PKT_LEN_RESET[LEN_MSB:0];
            waitForAckReply <= PARAM_A_RESET[WAIT_BIT];
            startOrderedSetChoice <= PARAM_A_RESET[SOP_MSB:SOP_LSB];
            expectedMsgId <= PARAM_A_RESET[MSGID_MSB:MSGID_LSB];
        end else if (regWrEn) begin
            if (regAddr == ADDR_PKT_LEN) begin
                txPacketLength <= regWrData[LEN_MSB:0];
            end
            if (regAddr == ADDR_PARAM_A) begin
                waitForAckReply <= regWrData[WAIT_BIT];
                startOrderedSetChoice <= regWrData[SOP_MSB:SOP_LSB];
                expectedMsgId <= regWrData[MSGID_MSB:MSGID_LSB];
            end
        end
    end

    // software send permit
    always_ff @(posedge clk) begin
        if (!rst_n || pdBlockReset) begin
            softwareSendPermit <= PARAM_A_RESET[PERMIT_BIT];
        end else if (holdPermit) begin
            softwareSendPermit <= 1'b0;
        end else if (regWrEn && regAddr == ADDR_PARAM_A) begin
            softwareSendPermit <= regWrData[PERMIT_BIT];
        end
    end

    // register reads
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdData <= 8'h00;
        end else if (regRdEn) begin
            if (regAddr == ADDR_PKT_LEN) begin
                regRdData <= {2'h0, txPacketLength};
            end else if (regAddr == ADDR_PARAM_A) begin
                regRdData <= {waitForAckReply, startOrderedSetChoice,
                    softwareSendPermit, expectedMsgId};
            end else begin
                regRdData <= 8'h00;
            end
        end
    end

    // dropped software request
    always_ff @(posedge clk) begin
        if (!rst_n || pdBlockReset) begin
            swDropped <= 1'b0;
        end else begin
            swDropped <= goSet && !swStart && (state == ST_IDLE);
        end
    end

    // transmit sequencer; the permit is not looked at once sending
    always_ff @(posedge clk) begin
        if (!rst_n || pdBlockReset) begin
            state <= ST_IDLE;
            hwSend <= 1'b0;
            retryCount <= 3'h0;
            txDone <= 1'b0;
            txSuccess <= 1'b0;
            retryAttempt <= 1'b0;
        end else begin
            txDone <= 1'b0;
            retryAttempt <= 1'b0;
            if (abortReq && state != ST_IDLE) begin
                state <= ST_IDLE;
                txDone <= 1'b1;
                txSuccess <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (start) begin
                            state <= ST_SEND;
                            hwSend <= !swStart;
                            retryCount <= 3'h0;
                            txSuccess <= 1'b0;
                        end
                    end
                    ST_SEND: begin
                        if (fifoPop) begin
                            if (rawMode && fifoData[8]) begin
                                state <= ST_FLUSH;
                            end else if (!rawMode && sentCount + 1'b1 == txPacketLength) begin
                                state <= ST_CRC;
                            end
                        end
                    end
                    ST_CRC: begin
                        if (loadSlot) begin
                            state <= ST_FLUSH;
                        end
                    end
                    ST_FLUSH: begin
                        if (endOfFrame) begin
                            if (needAck) begin
                                state <= ST_WAIT_ACK;
                            end else begin
                                state <= ST_IDLE;
                                txDone <= 1'b1;
                                txSuccess <= 1'b1;
                            end
                        end
                    end
                    ST_WAIT_ACK: begin
                        if (ackGood) begin
                            state <= ST_IDLE;
                            txDone <= 1'b1;
                            txSuccess <= 1'b1;
                        end else if (timeout) begin
                            if (effRetry && retryCount < retryLimit) begin
                                state <= ST_SEND;
                                retryCount <= retryCount + 1'b1;
                                retryAttempt <= 1'b1;
                            end else begin
                                state <= ST_IDLE;
                                txDone <= 1'b1;
                                txSuccess <= 1'b0;
                            end
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // byte counter
    always_ff @(posedge clk) begin
        if (!rst_n || pdBlockReset || state == ST_IDLE || state == ST_WAIT_ACK) begin
            sentCount <= '0;
        end else if (fifoPop) begin
            sentCount <= sentCount + 1'b1;
        end
    end

    // ack wait timer
    always_ff @(posedge clk) begin
        if (!rst_n || state != ST_WAIT_ACK) begin
            ackTimer <= '0;
        end else if (!timeout) begin
            ackTimer <= ackTimer + 1'b1;
        end
    end

    // output stage; bytes are forwarded exactly as queued
    always_ff @(posedge clk) begin
        if (!rst_n || pdBlockReset || (abortReq && state != ST_IDLE)) begin
            outValid <= 1'b0;
            outData <= 8'h00;
            outCrc <= 1'b0;
        end else if (fifoPop) begin
            outValid <= 1'b1;
            outData <= fifoData[7:0];
            outCrc <= rawMode && fifoData[8];
        end else if (state == ST_CRC && loadSlot) begin
            outValid <= 1'b1;
            outData <= 8'h00;
            outCrc <= 1'b1;
        end else if (outReady) begin
            outValid <= 1'b0;
            outCrc <= 1'b0;
        end
    end

    assign txActive = state != ST_IDLE;

    assign inReset = !rst_n || pdBlockReset;
    chk_permit_held: assert property (@(posedge clk) disable iff (!rst_n)
        holdPermit |=> !softwareSendPermit)
        else $error("permit not held clear");
    chk_permit_reset: assert property (@(posedge clk) disable iff (!rst_n)
        pdBlockReset |=> !softwareSendPermit)
        else $error("permit survives block reset");
    chk_drop_no_start: assert property (@(posedge clk) disable iff (inReset)
        state == ST_IDLE && goSet && !softwareSendPermit && !hwSendReq |=>
        state == ST_IDLE && swDropped)
        else $error("unpermitted request was started");
    chk_hw_not_gated: assert property (@(posedge clk) disable iff (inReset)
        state == ST_IDLE && hwSendReq && !abortReq |=> state == ST_SEND)
        else $error("hardware send blocked");
    chk_crc_after_len: assert property (@(posedge clk) disable iff (inReset)
        state == ST_SEND && !rawMode && fifoPop && !abortReq
        && sentCount == txPacketLength - 1'b1 |=> state == ST_CRC)
        else $error("crc not placed after length");
    chk_no_wait_nack: assert property (@(posedge clk) disable iff (inReset)
        state == ST_FLUSH && endOfFrame && !needAck && !abortReq |=>
        txDone && txSuccess && state == ST_IDLE)
        else $error("completed without wait rule");
    chk_forced_wait: assert property (@(posedge clk) disable iff (inReset)
        state == ST_FLUSH && endOfFrame && effRetry && !hwSend && !abortReq |=>
        state == ST_WAIT_ACK)
        else $error("retry mode did not wait for ack");
    chk_bad_ack_ignored: assert property (@(posedge clk) disable iff (inReset)
        state == ST_WAIT_ACK && ackValid && ackMsgId != expectedMsgId
        && !timeout && !abortReq |=> state == ST_WAIT_ACK && !txDone)
        else $error("mismatched ack accepted");
    chk_sop_checked: assert property (@(posedge clk) disable iff (inReset)
        state == ST_WAIT_ACK && ackValid && effRetry && ackSop != startOrderedSetChoice
        && !timeout && !abortReq |=> state == ST_WAIT_ACK && !txSuccess)
        else $error("ack with wrong sop accepted");
    chk_no_retry_zero: assert property (@(posedge clk) disable iff (inReset)
        !effRetry && state == ST_WAIT_ACK && timeout && !ackGood && !abortReq |=>
        state == ST_IDLE && !retryAttempt && !txSuccess)
        else $error("retry without retry enable");
    chk_pass_through: assert property (@(posedge clk) disable iff (inReset)
        fifoPop && !abortReq |=> outValid && outData == $past(fifoData[7:0]))
        else $error("byte altered on output");
endmodule // ptx_message_params

// ===== ptx_pkg.sv
package ptx_pkg;
    // register map
    localparam logic [15:0] ADDR_PKT_LEN = 16'h1A03;
    localparam logic [15:0] ADDR_PARAM_A = 16'h1A04;
    localparam logic [7:0] PKT_LEN_RESET = 8'h00;
    localparam logic [7:0] PARAM_A_RESET = 8'h00;

    // field positions
    localparam int LEN_MSB = 5;
    localparam int LEN_W = 6;
    localparam int WAIT_BIT = 7;
    localparam int SOP_MSB = 6;
    localparam int SOP_LSB = 4;
    localparam int PERMIT_BIT = 3;
    localparam int MSGID_MSB = 2;
    localparam int MSGID_LSB = 0;

    // start-of-packet choices
    localparam logic [2:0] SOP_PLAIN = 3'h0;
    localparam logic [2:0] SOP_PRIME = 3'h1;
    localparam logic [2:0] SOP_DPRIME = 3'h2;
    localparam logic [2:0] SOP_PRIME_DEBUG = 3'h3;
    localparam logic [2:0] SOP_DPRIME_DEBUG = 3'h4;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int ACK_WAIT_NS = 1000;
    localparam int ACK_WAIT_CYCLES = (ACK_WAIT_NS / CLK_PERIOD_NS) < 1 ? 1
        : (ACK_WAIT_NS / CLK_PERIOD_NS);

    // queue buffer
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_WIDTH = 9;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SEND,
        ST_CRC,
        ST_FLUSH,
        ST_WAIT_ACK
    } ptx_state_t;
endpackage

// ===== ptx_fifo.sv
module ptx_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
    logic push;
    logic pop;

    assign inReady = (wrPtr - rdPtr) != (AW+1)'(DEPTH);
    assign outValid = wrPtr != rdPtr;
    assign outData = mem[rdPtr[AW-1:0]];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || flush) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            if (push) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (pop) begin
                rdPtr <= rdPtr + 1'b1;
            end
        end
    end
endmodule // ptx_fifo

// ===== ptx_partner_model.sv
module ptx_partner_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic outValid,
    input wire logic [7:0] outData,
    input wire logic outCrc,
    output logic outReady,
    input wire logic stall,
    input wire logic ackOn,
    input wire logic [2:0] ackSopIn,
    input wire logic [2:0] ackIdIn,
    output logic ackValid,
    output logic [2:0] ackSop,
    output logic [2:0] ackMsgId,
    output logic [7:0] beats,
    output logic [7:0] dataSum
);
    logic noise;
    logic [1:0] delay;
    // slow mode takes a beat every other cycle
    assign outReady = !stall || noise;
    // reply fields carry no stale value outside a reply
    assign ackSop = ackValid ? ackSopIn : {3{noise}};
    assign ackMsgId = ackValid ? ackIdIn : {3{noise}};
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            noise <= 1'b0;
            beats <= 8'h00;
            dataSum <= 8'h00;
            delay <= 2'h0;
            ackValid <= 1'b0;
        end else begin
            noise <= !noise;
            ackValid <= (delay == 2'h1);
            delay <= (delay != 2'h0) ? delay - 2'h1 : 2'h0;
            if (outValid && outReady) begin
                beats <= beats + 8'h01;
                if (!outCrc) begin
                    dataSum <= dataSum ^ outData;
                end
                // reply follows the end-of-packet beat
                if (outCrc && ackOn) begin
                    delay <= 2'h2;
                end
            end
        end
    end
endmodule // ptx_partner_model

// ===== ptx_message_params_tb.sv
module ptx_message_params_tb import ptx_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, pdBlockReset = 0, regWrEn = 0, regRdEn = 0, rawMode = 0;
    logic autoReplyEnable = 0, rxHardReset = 0, rxCableReset = 0, rxFifoNotEmpty = 0;
    logic goSet = 0, hwSendReq = 0, abortReq = 0, qValid = 0, qSpecial = 0, stall = 0, ackOn = 0;
    logic [15:0] regAddr = 0;
    logic [7:0] regWrData = 0, qData = 0, regRdData, outData, beats, dataSum;
    logic [2:0] retryLimit = 0, ackSopIn = 0, ackIdIn = 0, startOrderedSet, ackSop, ackMsgId;
    logic [2:0] retryCount;
    logic qReady, outValid, outCrc, outReady, ackValid, txActive, txDone, txSuccess;
    logic swDropped, retryAttempt;
    int failures = 0, samplesChecked = 0;
    always #5 clk = !clk;

    ptx_message_params #(.ACK_WAIT(4)) dut (.clk(clk), .rst_n(rst_n),
        .pdBlockReset(pdBlockReset), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .rawMode(rawMode),
        .autoReplyEnable(autoReplyEnable), .retryLimit(retryLimit), .rxHardReset(rxHardReset),
        .rxCableReset(rxCableReset), .rxFifoNotEmpty(rxFifoNotEmpty), .goSet(goSet),
        .hwSendReq(hwSendReq), .abortReq(abortReq), .qValid(qValid), .qData(qData),
        .qSpecial(qSpecial), .qReady(qReady), .outValid(outValid), .outData(outData),
        .outCrc(outCrc), .outReady(outReady), .startOrderedSet(startOrderedSet),
        .ackValid(ackValid), .ackSop(ackSop), .ackMsgId(ackMsgId), .txActive(txActive),
        .txDone(txDone), .txSuccess(txSuccess), .swDropped(swDropped),
        .retryAttempt(retryAttempt), .retryCount(retryCount));
    ptx_partner_model partner (.clk(clk), .rst_n(rst_n), .outValid(outValid),
        .outData(outData), .outCrc(outCrc), .outReady(outReady), .stall(stall), .ackOn(ackOn),
        .ackSopIn(ackSopIn), .ackIdIn(ackIdIn), .ackValid(ackValid), .ackSop(ackSop),
        .ackMsgId(ackMsgId), .beats(beats), .dataSum(dataSum));

    task summarize();
        $display("checks %0d, mismatches %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task check(input logic [7:0] seen, input logic [7:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1;
        @(negedge clk);
        regWrEn = 0;
    endtask
    task rd(input logic [15:0] a, input logic [7:0] exp);
        @(negedge clk);
        regAddr = a;
        regRdEn = 1;
        @(negedge clk);
        regRdEn = 0;
        check(regRdData, exp);
    endtask
    task push(input logic [7:0] d, input logic s);
        @(negedge clk);
        qValid = 1;
        qData = d;
        qSpecial = s;
        @(negedge clk);
        qValid = 0;
    endtask
    task go(input logic hw);
        @(negedge clk);
        goSet = !hw;
        hwSendReq = hw;
        @(negedge clk);
        goSet = 0;
        hwSendReq = 0;
    endtask
    task waitDone();
        int n;
        n = 0;
        while (txDone !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        if (n >= 400) begin
            failures++;
            summarize();
        end
    endtask

    task test_regs();
        rd(ADDR_PKT_LEN, PKT_LEN_RESET);
        rd(ADDR_PARAM_A, PARAM_A_RESET);
        wr(ADDR_PKT_LEN, 8'hFF);
        rd(ADDR_PKT_LEN, 8'h3F);
        wr(16'h1A05, 8'h55);
        rd(16'h1A05, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_PARAM_A, {1'b0, i[2:0], 4'h0});
            check({5'h00, startOrderedSet}, {5'h00, i[2:0]});
        end
        for (int h = 0; h < 3; h++) begin
            {rxHardReset, rxCableReset, rxFifoNotEmpty} = 3'h1 << h;
            wr(ADDR_PARAM_A, 8'h0F);
            rd(ADDR_PARAM_A, 8'h07);
            {rxHardReset, rxCableReset, rxFifoNotEmpty} = 3'h0;
        end
        wr(ADDR_PARAM_A, 8'h0F);
        pdBlockReset = 1;
        repeat (2) @(negedge clk);
        pdBlockReset = 0;
        rd(ADDR_PARAM_A, 8'h00);
        wr(ADDR_PARAM_A, 8'h00);
        $display("test regs done");
    endtask
    task test_auto();
        logic [7:0] b0, s0;
        wr(ADDR_PKT_LEN, 8'h03);
        wr(ADDR_PARAM_A, 8'h08);
        push(8'hA1, 0);
        push(8'hB2, 0);
        push(8'hC3, 0);
        b0 = beats;
        s0 = dataSum;
        stall = 1;
        go(0);
        wr(ADDR_PARAM_A, 8'h00);
        waitDone();
        check({7'h00, txSuccess}, 8'h01);
        check(beats - b0, 8'h04);
        check(dataSum ^ s0, 8'hA1 ^ 8'hB2 ^ 8'hC3);
        stall = 0;
        $display("test auto done");
    endtask
    task test_raw_fill();
        logic [7:0] b0, x;
        rawMode = 1;
        stall = 1;
        x = dataSum;
        b0 = beats;
        for (int i = 0; i < 15; i++) begin
            push(8'h30 + i[7:0], 0);
            x = x ^ (8'h30 + i[7:0]);
        end
        push(8'h5A, 1);
        check({7'h00, qReady}, 8'h00);
        wr(ADDR_PARAM_A, 8'h08);
        go(0);
        waitDone();
        check({7'h00, txSuccess}, 8'h01);
        check(beats - b0, 8'h10);
        check(dataSum, x);
        check({7'h00, qReady}, 8'h01);
        rawMode = 0;
        stall = 0;
        $display("test raw done");
    endtask
    task test_drop_hw();
        logic [7:0] b0;
        wr(ADDR_PARAM_A, 8'h80);
        @(negedge clk);
        goSet = 1;
        @(negedge clk);
        goSet = 0;
        check({7'h00, swDropped}, 8'h01);
        check({7'h00, txActive}, 8'h00);
        push(8'h11, 0);
        push(8'h22, 0);
        push(8'h33, 0);
        b0 = beats;
        go(1);
        waitDone();
        check({7'h00, txSuccess}, 8'h01);
        check(beats - b0, 8'h04);
        $display("test drop hw done");
    endtask
    task test_ack();
        ackOn = 1;
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_PARAM_A, 8'h8D);
            ackIdIn = k ? 3'h5 : 3'h3;
            push(8'h01, 0);
            push(8'h0A, 0);
            push(8'h00, 0);
            go(0);
            waitDone();
            check({7'h00, txSuccess}, {7'h00, k[0]});
        end
        $display("test ack done");
    endtask
    task test_retry();
        int n;
        retryLimit = 3'h1;
        ackIdIn = 3'h5;
        for (int k = 0; k < 3; k++) begin
            autoReplyEnable = (k != 2);
            ackOn = (k != 2);
            ackSopIn = k ? 3'h2 : 3'h1;
            wr(ADDR_PARAM_A, 8'h2D);
            push(8'h01, 0);
            push(8'h0A, 0);
            push(8'h00, 0);
            go(0);
            if (k == 0) begin
                n = 0;
                while (retryAttempt !== 1'b1 && n < 50) begin
                    @(negedge clk);
                    n++;
                end
                if (n >= 50) begin
                    failures++;
                    summarize();
                end
                check({7'h00, retryAttempt}, 8'h01);
                check({5'h00, retryCount}, 8'h01);
                abortReq = 1;
                @(negedge clk);
                abortReq = 0;
            end
            waitDone();
            check({7'h00, txSuccess}, {7'h00, k != 0});
            @(negedge clk);
            check({7'h00, txActive}, 8'h00);
        end
        $display("test retry done");
    endtask

    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1;
        test_regs();
        test_auto();
        test_raw_fill();
        test_drop_hw();
        test_ack();
        test_retry();
        summarize();
    end
endmodule // ptx_message_params_tb
